// ===== core/irp_params.svh
// timing, layout and reset constants for the ir pulse-distance codec
`ifndef IRP_PARAMS_SVH
`define IRP_PARAMS_SVH

`define IRP_CLK_NS 40
`define IRP_CYC_UP(ns) (((ns) + `IRP_CLK_NS - 1) / `IRP_CLK_NS)
`define IRP_CYC_DN(ns) ((ns) / `IRP_CLK_NS)

`define IRP_BURST_NS 562500
`define IRP_ZERO_SPACE_NS 562500
`define IRP_ONE_SPACE_NS 1687500
`define IRP_LEAD_BURST_NS 9000000
`define IRP_LEAD_SPACE_NS 4500000
`define IRP_CARRIER_HALF_NS 13158
`define IRP_CARRIER_HALF_CYC `IRP_CYC_DN(`IRP_CARRIER_HALF_NS)

`define IRP_FRAME_BITS 32
`define IRP_FIFO_DEPTH 32
`define IRP_WORD_W 16
`define IRP_CNT_W 18

`define IRP_WORD_ADDR_LSB 0
`define IRP_WORD_CMD_LSB 8
`define IRP_FRM_ADDR_LSB 0
`define IRP_FRM_NADDR_LSB 8
`define IRP_FRM_CMD_LSB 16
`define IRP_FRM_NCMD_LSB 24

`define IRP_SEG_RESET 7'h7F

`endif

// ===== core/irp_pkg.sv
// state types for the ir pulse-distance codec
package irp_pkg;

  typedef enum logic [5:0] {
    TX_IDLE       = 6'h01,
    TX_LEAD_BURST = 6'h02,
    TX_LEAD_SPACE = 6'h04,
    TX_BIT_BURST  = 6'h08,
    TX_BIT_SPACE  = 6'h10,
    TX_END_BURST  = 6'h20
  } irp_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE      = 3'h1,
    RX_LEAD_SEEN = 3'h2,
    RX_BIT_COLL  = 3'h4
  } irp_rx_state_t;

endpackage

// ===== core/irp_stream_if.sv
// valid/ready word stream between the codec's own modules
`timescale 1ns/1ps
interface irp_stream_if #(parameter int unsigned W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ===== core/irp_fifo.sv
// payload fifo with registered read data and flush
`timescale 1ns/1ps
module irp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic flush,
  // streams
  irp_stream_if.sink wr,
  irp_stream_if.source rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire full = (cnt_reg == (AW+1)'(DEPTH));
  wire empty = (cnt_reg == '0);
  wire push = wr.valid & ~full;
  // refill the output register when it is free or being taken
  wire load = ~empty & (~out_valid_reg | rd.ready);
  wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(load);

  assign wr.ready = ~full;
  assign rd.valid = out_valid_reg;
  assign rd.data = out_data_reg;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wp_reg] <= wr.data;
    if (load)
      out_data_reg <= mem[rp_reg];
  end

  // pointers wrap naturally: depth is a power of two
  always_ff @(posedge core_clk)
  begin
    if (srst || flush)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      wp_reg <= push ? wp_reg + 1'b1 : wp_reg;
      rp_reg <= load ? rp_reg + 1'b1 : rp_reg;
      cnt_reg <= cnt_next;
      out_valid_reg <= load | (out_valid_reg & ~rd.ready);
    end
  end
endmodule // irp_fifo

// ===== core/irp_seg7.sv
// registered hex nibble to seven-segment decoder
`timescale 1ns/1ps
`include "irp_params.svh"
module irp_seg7 #(
  parameter bit ACTIVE_LOW = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // nibble in, segments out (g..a)
  input wire logic [3:0] nibble,
  output logic [6:0] seg
);
  logic [6:0] pat;

  always_comb
  begin
    unique case (nibble)
      4'h0: pat = 7'h3F;
      4'h1: pat = 7'h06;
      4'h2: pat = 7'h5B;
      4'h3: pat = 7'h4F;
      4'h4: pat = 7'h66;
      4'h5: pat = 7'h6D;
      4'h6: pat = 7'h7D;
      4'h7: pat = 7'h07;
      4'h8: pat = 7'h7F;
      4'h9: pat = 7'h6F;
      4'hA: pat = 7'h77;
      4'hB: pat = 7'h7C;
      4'hC: pat = 7'h39;
      4'hD: pat = 7'h5E;
      4'hE: pat = 7'h79;
      4'hF: pat = 7'h71;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      seg <= `IRP_SEG_RESET;
    else
      seg <= ACTIVE_LOW ? ~pat : pat;
  end
endmodule // irp_seg7

// ===== core/irp_codec.sv
// ir pulse-distance transmitter and receiver with hex display
// What this block does
// - takes 8-bit address and command payload
// - transmit timing counted in core clock cycles
// - fixed burst, bit value in space length
// - 562.5us bursts toggling at 38kHz carrier
// - zero: burst plus 562.5us space
// - one: burst plus 1.6875ms space
// - frame opens with 9ms burst, 4.5ms space
// - each byte sent true then inverted
// - final 562.5us burst ends the frame
// - every frame has identical total length
// - held button streams pattern frames, release stops
// - receive input is inverted: burst reads low
// - idle to lead-seen on a lead burst of at least 3/4 length
// - lead-seen to bit-collect on address start
// - received bits shifted into display register
// - receive widths measured in core clock cycles
// - digits show inverted command, address, command
`timescale 1ns/1ps
`include "irp_params.svh"
module irp_codec #(
  parameter int unsigned BURST_CYC = `IRP_CYC_UP(`IRP_BURST_NS),
  parameter int unsigned ZERO_SPACE_CYC = `IRP_CYC_UP(`IRP_ZERO_SPACE_NS),
  parameter int unsigned ONE_SPACE_CYC = `IRP_CYC_UP(`IRP_ONE_SPACE_NS),
  parameter int unsigned LEAD_BURST_CYC = `IRP_CYC_UP(`IRP_LEAD_BURST_NS),
  parameter int unsigned LEAD_SPACE_CYC = `IRP_CYC_UP(`IRP_LEAD_SPACE_NS),
  parameter int unsigned CAR_HALF_CYC = `IRP_CARRIER_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = `IRP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // transmit payload and control
  input wire logic [7:0] tx_addr,
  input wire logic [7:0] tx_cmd,
  input wire logic transmit_hold_button,
  // emitter and receiver pins
  output logic ir_tx_out,
  input wire logic ir_rx_in,
  // receive status and displays
  output logic rx_frame_done,
  output logic [6:0] digit_display_0,
  output logic [6:0] digit_display_1,
  output logic [6:0] digit_display_2,
  output logic [6:0] digit_display_3,
  output logic [6:0] digit_display_4,
  output logic [6:0] digit_display_5
);
  localparam int CW = `IRP_CNT_W;
  localparam int NB = `IRP_FRAME_BITS;
  localparam logic [CW-1:0] BURST_LAST = CW'(BURST_CYC - 1);
  localparam logic [CW-1:0] ZERO_LAST = CW'(ZERO_SPACE_CYC - 1);
  localparam logic [CW-1:0] ONE_LAST = CW'(ONE_SPACE_CYC - 1);
  localparam logic [CW-1:0] LEADB_LAST = CW'(LEAD_BURST_CYC - 1);
  localparam logic [CW-1:0] LEADS_LAST = CW'(LEAD_SPACE_CYC - 1);
  localparam logic [CW-1:0] CAR_LAST = CW'(CAR_HALF_CYC - 1);
  localparam logic [CW-1:0] LEAD_LOW_MIN = CW'(LEAD_BURST_CYC * 3 / 4);
  localparam logic [CW-1:0] LEAD_HIGH_MIN = CW'(LEAD_SPACE_CYC * 3 / 4);
  localparam logic [CW-1:0] BIT_MID = CW'((ZERO_SPACE_CYC + ONE_SPACE_CYC) / 2);
  localparam logic [CW-1:0] BIT_HIGH_MAX = CW'(ONE_SPACE_CYC * 2);
  localparam logic [CW-1:0] BURST_LOW_MAX = CW'(BURST_CYC * 2);
  localparam logic [CW-1:0] LEAD_HIGH_MAX = CW'(LEAD_SPACE_CYC * 2);
  localparam int unsigned FRAME_LAST = LEAD_BURST_CYC + LEAD_SPACE_CYC
    + (NB + 1) * BURST_CYC + (NB / 2) * (ZERO_SPACE_CYC + ONE_SPACE_CYC) - 1;

  // ---------------- test pattern source into the fifo
  irp_stream_if #(.W(`IRP_WORD_W)) pat_if ();
  irp_stream_if #(.W(`IRP_WORD_W)) txq_if ();
  logic [7:0] pat_cnt_reg;
  wire pat_take = pat_if.valid & pat_if.ready;

  assign pat_if.valid = transmit_hold_button;
  assign pat_if.data = {tx_cmd + pat_cnt_reg, tx_addr};

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pat_cnt_reg <= 8'h00;
    else if (pat_take)
      pat_cnt_reg <= pat_cnt_reg + 8'h01;
  end

  // queued frames are dropped once the button is let go
  irp_fifo #(.WIDTH(`IRP_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .flush(~transmit_hold_button),
    .wr(pat_if),
    .rd(txq_if)
  );

  // ---------------- transmitter
  irp_pkg::irp_tx_state_t tx_state_reg;
  irp_pkg::irp_tx_state_t tx_state_next;
  logic [CW-1:0] tx_cnt_reg;
  logic [NB-1:0] tx_sh_reg;
  logic [4:0] tx_bit_reg;
  logic [CW-1:0] car_cnt_reg;
  logic car_reg;
  logic [31:0] frm_cnt_reg;

  wire [7:0] q_addr = txq_if.data[`IRP_WORD_ADDR_LSB +: 8];
  wire [7:0] q_cmd = txq_if.data[`IRP_WORD_CMD_LSB +: 8];
  wire [NB-1:0] tx_frame = {~q_cmd, q_cmd, ~q_addr, q_addr};
  wire tx_start = transmit_hold_button & txq_if.valid;
  wire tx_in_burst = (tx_state_reg == irp_pkg::TX_LEAD_BURST)
    | (tx_state_reg == irp_pkg::TX_BIT_BURST)
    | (tx_state_reg == irp_pkg::TX_END_BURST);
  wire [CW-1:0] tx_space_last = tx_sh_reg[0] ? ONE_LAST : ZERO_LAST;
  wire [CW-1:0] tx_limit =
    (tx_state_reg == irp_pkg::TX_LEAD_BURST) ? LEADB_LAST :
    (tx_state_reg == irp_pkg::TX_LEAD_SPACE) ? LEADS_LAST :
    (tx_state_reg == irp_pkg::TX_BIT_SPACE) ? tx_space_last : BURST_LAST;
  wire tx_end = (tx_cnt_reg == tx_limit);
  wire tx_last_bit = (tx_bit_reg == 5'(NB - 1));
  wire car_tick = (car_cnt_reg == CAR_LAST);

  assign txq_if.ready = (tx_state_reg == irp_pkg::TX_IDLE) & transmit_hold_button;

  always_comb
  begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      irp_pkg::TX_IDLE:
        if (tx_start)
          tx_state_next = irp_pkg::TX_LEAD_BURST;
      irp_pkg::TX_LEAD_BURST:
        if (tx_end)
          tx_state_next = irp_pkg::TX_LEAD_SPACE;
      irp_pkg::TX_LEAD_SPACE:
        if (tx_end)
          tx_state_next = irp_pkg::TX_BIT_BURST;
      irp_pkg::TX_BIT_BURST:
        if (tx_end)
          tx_state_next = irp_pkg::TX_BIT_SPACE;
      irp_pkg::TX_BIT_SPACE:
        if (tx_end)
          tx_state_next = tx_last_bit ? irp_pkg::TX_END_BURST : irp_pkg::TX_BIT_BURST;
      irp_pkg::TX_END_BURST:
        if (tx_end)
          tx_state_next = irp_pkg::TX_IDLE;
      default:
        tx_state_next = irp_pkg::TX_IDLE;
    endcase
  end

  wire tx_move = (tx_state_next != tx_state_reg);
  wire tx_shift = (tx_state_reg == irp_pkg::TX_BIT_SPACE) & tx_end;
  wire [NB-1:0] tx_sh_next = (tx_state_reg == irp_pkg::TX_IDLE) ? tx_frame :
    tx_shift ? {1'b0, tx_sh_reg[NB-1:1]} : tx_sh_reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_state_reg <= irp_pkg::TX_IDLE;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '0;
      tx_bit_reg <= '0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_move ? '0 : tx_cnt_reg + 1'b1;
      tx_sh_reg <= tx_sh_next;
      tx_bit_reg <= (tx_state_reg == irp_pkg::TX_IDLE) ? 5'h00 : tx_bit_reg + 5'(tx_shift);
    end
  end

  // carrier restarts high at every burst so each burst has the same shape
  always_ff @(posedge core_clk)
  begin
    if (srst || !tx_in_burst)
    begin
      car_cnt_reg <= '0;
      car_reg <= 1'b1;
    end
    else
    begin
      car_cnt_reg <= car_tick ? '0 : car_cnt_reg + 1'b1;
      car_reg <= car_reg ^ car_tick;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ir_tx_out <= 1'b0;
      frm_cnt_reg <= '0;
    end
    else
    begin
      ir_tx_out <= tx_in_burst & car_reg;
      frm_cnt_reg <= (tx_state_reg == irp_pkg::TX_IDLE) ? 32'h0 : frm_cnt_reg + 32'h1;
    end
  end

  // ---------------- receiver: low on the pin is carrier present
  irp_pkg::irp_rx_state_t rx_state_reg;
  irp_pkg::irp_rx_state_t rx_state_next;
  logic rx_q_reg;
  logic [CW-1:0] run_reg;
  logic [NB-1:0] rx_sh_reg;
  logic [5:0] rx_bit_reg;
  logic [NB-1:0] disp_reg;

  wire rx_rise = ir_rx_in & ~rx_q_reg;
  wire rx_fall = ~ir_rx_in & rx_q_reg;
  wire lead_ok = rx_rise & (run_reg >= LEAD_LOW_MIN);
  wire addr_ok = rx_fall & (run_reg >= LEAD_HIGH_MIN);
  wire bit_val = (run_reg >= BIT_MID);
  wire rx_bad = (rx_rise & (run_reg > BURST_LOW_MAX))
    | (rx_q_reg & (run_reg > BIT_HIGH_MAX));
  wire rx_got_bit = (rx_state_reg == irp_pkg::RX_BIT_COLL) & rx_fall & ~rx_bad;
  wire rx_done = rx_got_bit & (rx_bit_reg == 6'(NB - 1));
  wire run_sat = &run_reg;
  // lead space outlasts a bit space, so it gets its own upper bound
  wire lead_bad = rx_q_reg & (run_reg > LEAD_HIGH_MAX);

  always_comb
  begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      irp_pkg::RX_IDLE:
        if (lead_ok)
          rx_state_next = irp_pkg::RX_LEAD_SEEN;
      irp_pkg::RX_LEAD_SEEN:
        if (addr_ok)
          rx_state_next = irp_pkg::RX_BIT_COLL;
        else if (rx_fall || lead_bad)
          rx_state_next = irp_pkg::RX_IDLE;
      irp_pkg::RX_BIT_COLL:
        if (rx_bad || rx_done)
          rx_state_next = irp_pkg::RX_IDLE;
      default:
        rx_state_next = irp_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_state_reg <= irp_pkg::RX_IDLE;
      rx_q_reg <= 1'b1;
      run_reg <= '0;
      rx_sh_reg <= '0;
      rx_bit_reg <= '0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_q_reg <= ir_rx_in;
      run_reg <= (rx_rise | rx_fall) ? '0 : (run_sat ? run_reg : run_reg + 1'b1);
      if (rx_got_bit)
        rx_sh_reg <= {bit_val, rx_sh_reg[NB-1:1]};
      rx_bit_reg <= (rx_state_reg != irp_pkg::RX_BIT_COLL) ? 6'h00 : rx_bit_reg + 6'(rx_got_bit);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      disp_reg <= '0;
      rx_frame_done <= 1'b0;
    end
    else
    begin
      rx_frame_done <= rx_done;
      if (rx_done)
        disp_reg <= {bit_val, rx_sh_reg[NB-1:1]};
    end
  end

  // ---------------- displays: digit 0 is least significant
  wire [23:0] disp_nib = {disp_reg[`IRP_FRM_NCMD_LSB +: 8],
    disp_reg[`IRP_FRM_ADDR_LSB +: 8], disp_reg[`IRP_FRM_CMD_LSB +: 8]};
  logic [6:0] seg_arr [6];

  for (genvar i = 0; i < 6; i++)
  begin : g_digit
    irp_seg7 #(.ACTIVE_LOW(1'b1)) u_seg (
      .core_clk(core_clk),
      .srst(srst),
      .nibble(disp_nib[4*i +: 4]),
      .seg(seg_arr[i])
    );
  end

  assign digit_display_0 = seg_arr[0];
  assign digit_display_1 = seg_arr[1];
  assign digit_display_2 = seg_arr[2];
  assign digit_display_3 = seg_arr[3];
  assign digit_display_4 = seg_arr[4];
  assign digit_display_5 = seg_arr[5];

  // ---------------- checks
  tx_carrier_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    ir_tx_out |-> $past(tx_in_burst))
    else $error("emitter active outside a burst");

  tx_lead_len_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tx_state_reg == irp_pkg::TX_LEAD_SPACE) |-> $past(tx_cnt_reg) == LEADB_LAST)
    else $error("lead burst length wrong");

  tx_bit_space_a: assert property (@(posedge core_clk) disable iff (srst)
    (tx_state_reg == irp_pkg::TX_BIT_SPACE) && tx_end
    |-> tx_cnt_reg == (tx_sh_reg[0] ? ONE_LAST : ZERO_LAST))
    else $error("bit space length wrong");

  tx_burst_len_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(tx_state_reg == irp_pkg::TX_BIT_BURST) |-> $past(tx_cnt_reg) == BURST_LAST)
    else $error("bit burst length wrong");

  tx_end_burst_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tx_state_reg == irp_pkg::TX_END_BURST) |-> $past(tx_bit_reg) == 5'(NB - 1))
    else $error("end burst before all bits");

  tx_byte_pair_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tx_state_reg == irp_pkg::TX_LEAD_BURST)
    |-> tx_sh_reg[15:8] == ~tx_sh_reg[7:0] && tx_sh_reg[31:24] == ~tx_sh_reg[23:16])
    else $error("inverse byte not paired");

  tx_frame_len_a: assert property (@(posedge core_clk) disable iff (srst)
    (tx_state_reg == irp_pkg::TX_END_BURST) && tx_end |-> frm_cnt_reg == 32'(FRAME_LAST))
    else $error("frame length not constant");

  tx_release_stop_a: assert property (@(posedge core_clk) disable iff (srst)
    !transmit_hold_button && tx_state_reg == irp_pkg::TX_IDLE
    |=> tx_state_reg == irp_pkg::TX_IDLE)
    else $error("frame started without button");

  rx_lead_enter_a: assert property (@(posedge core_clk) disable iff (srst)
    $changed(rx_state_reg) && rx_state_reg != irp_pkg::RX_IDLE
    |-> $past(lead_ok) || $past(addr_ok))
    else $error("receive state left idle without a code");

  rx_frame_show_a: assert property (@(posedge core_clk) disable iff (srst)
    rx_frame_done |=> $changed(digit_display_0) || disp_nib[3:0] == $past(disp_nib[3:0], 2))
    else $error("display not fed from received frame");
endmodule // irp_codec

// ===== testbench/irp_far_model.sv
// far-side model: demodulating receiver module and handheld remote
`timescale 1ns/1ps
module irp_far_model #(
  parameter int B = 20,
  parameter int Z = 20,
  parameter int O = 60,
  parameter int LB = 320,
  parameter int LS = 160,
  parameter int CH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // emitter side and mode select
  input wire logic ir_tx_out,
  input wire logic remote_mode,
  // receiver pin
  output logic ir_rx_in
);
  logic rem_reg = 1'b1;
  int hold = 0;
  // envelope holds across the carrier's low halves
  always @(posedge core_clk)
    hold <= srst ? 0 : (ir_tx_out ? 2 * CH : (hold > 0 ? hold - 1 : 0));
  assign ir_rx_in = remote_mode ? rem_reg : !(ir_tx_out || hold > 0);
  task automatic level(input logic v, input int n);
    @(posedge core_clk);
    rem_reg <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask
  // short lead space mimics a repeat code
  task automatic send(input logic [7:0] a, input logic [7:0] c, input bit rpt);
    logic [31:0] w;
    w = {~c, c, ~a, a};
    level(1'b0, LB);
    level(1'b1, rpt ? LS / 2 : LS);
    for (int i = 0; i < 32 && !rpt; i++)
    begin
      level(1'b0, B);
      level(1'b1, w[i] ? O : Z);
    end
    level(1'b0, B);
    level(1'b1, 1);
  endtask
endmodule // irp_far_model

// ===== testbench/testbench.sv
// self-checking bench for the ir pulse-distance codec
`timescale 1ns/1ps
module testbench;
  localparam int B = 20, Z = 20, O = 60, LB = 320, LS = 160, CH = 4, QD = 32;
  localparam int FRM = LB + LS + 33 * B + 16 * (Z + O);
  localparam logic [6:0] SG [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
    7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  localparam logic [7:0] KEYS [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0F};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] tx_addr = 8'h00;
  logic [7:0] tx_cmd = 8'h00;
  logic btn = 1'b0;
  logic rem = 1'b1;
  logic ir_tx_out, ir_rx_in, done;
  logic [6:0] d [6];
  logic [7:0] ea, eb;
  logic [31:0] bits;
  int bad_count = 0, tests_run = 0, frames, nbits, run_lo, run_hi, flen, ndone;
  bit in_frm;
  wire logic [41:0] dsp = {d[5], d[4], d[3], d[2], d[1], d[0]};
  irp_codec #(.BURST_CYC(B), .ZERO_SPACE_CYC(Z), .ONE_SPACE_CYC(O), .LEAD_BURST_CYC(LB),
    .LEAD_SPACE_CYC(LS), .CAR_HALF_CYC(CH), .FIFO_DEPTH(QD)) i_irp_codec (
    .core_clk(core_clk), .srst(srst), .tx_addr(tx_addr), .tx_cmd(tx_cmd),
    .transmit_hold_button(btn), .ir_tx_out(ir_tx_out), .ir_rx_in(ir_rx_in),
    .rx_frame_done(done), .digit_display_0(d[0]), .digit_display_1(d[1]),
    .digit_display_2(d[2]), .digit_display_3(d[3]), .digit_display_4(d[4]),
    .digit_display_5(d[5]));
  irp_far_model #(.B(B), .Z(Z), .O(O), .LB(LB), .LS(LS), .CH(CH)) i_irp_far_model (
    .core_clk(core_clk), .srst(srst), .ir_tx_out(ir_tx_out), .remote_mode(rem),
    .ir_rx_in(ir_rx_in));
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [41:0] disp(input logic [7:0] a, input logic [7:0] c);
    return ~{SG[~c[7:4]], SG[~c[3:0]], SG[a[7:4]], SG[a[3:0]], SG[c[7:4]], SG[c[3:0]]};
  endfunction
  task automatic chk_v(input logic [41:0] got, input logic [41:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string m);
    tests_run++;
    if (got != exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %0d", $time, m, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    #1 chk_v(dsp, {42{1'b1}}, "display in reset");
    repeat (3) @(posedge core_clk);
    #1 chk_v(dsp, {6{7'h40}}, "display after reset");
  endtask
  // judges one frame seen on the emitter wire
  task automatic end_frame();
    logic [7:0] cc;
    cc = eb + 8'(frames - 1);
    if (in_frm)
    begin
      chk_n(flen - run_lo, FRM, "frame length");
      chk_n(nbits, 32, "bit count");
      chk_v(bits, {~cc, cc, ~ea, ea}, "frame bits");
    end
    in_frm = 1'b0;
  endtask
  always @(negedge core_clk)
    if (srst)
    begin
      {frames, nbits, run_lo, run_hi, flen, ndone} = '0;
      in_frm = 1'b0;
    end
    else
    begin
      ndone += (done === 1'b1);
      if (ir_tx_out === 1'b1)
      begin
        if (in_frm && (run_lo == Z || run_lo == O))
        begin
          bits = {run_lo == O, bits[31:1]};
          nbits++;
        end
        else if (run_lo > 0 && !(in_frm && (run_lo == CH || run_lo == CH + LS)))
        begin
          end_frame();
          in_frm = 1'b1;
          frames++;
          flen = 0;
          nbits = 0;
        end
        run_lo = 0;
        run_hi++;
        flen++;
      end
      else
      begin
        if (run_hi > 0)
          chk_n(run_hi, CH, "carrier high");
        run_hi = 0;
        run_lo++;
        flen += in_frm;
        if (run_lo == 200)
          end_frame();
      end
    end
  // full queue dropped on release, frame in flight still ends
  task automatic fifo_run(input logic [7:0] a, input logic [7:0] c);
    logic [7:0] c2;
    do_reset();
    ea = a;
    eb = c;
    c2 = 8'($urandom);
    @(posedge core_clk);
    tx_addr <= a;
    tx_cmd <= c;
    btn <= 1'b1;
    rem <= 1'b0;
    wait (frames == 2);
    @(posedge core_clk);
    btn <= 1'b0;
    tx_cmd <= c2;
    repeat (FRM + 300) @(posedge core_clk);
    #1 chk_n(frames, 2, "frame in flight");
    chk_v(dsp, disp(a, c + 8'h01), "display before drop");
    // count ran on by two frames, queue depth and registered head
    eb = c2 + 8'(QD + 1);
    @(posedge core_clk);
    btn <= 1'b1;
    wait (frames == 3);
    @(posedge core_clk);
    btn <= 1'b0;
    repeat (FRM + 300) @(posedge core_clk);
    #1 chk_n(frames, 3, "frames after drop");
    chk_v(dsp, disp(a, c2 + 8'(2 + QD + 1)), "display after drop");
  endtask
  task automatic tx_run(input logic [7:0] a, input logic [7:0] c);
    int k;
    do_reset();
    ea = a;
    eb = c;
    k = 0;
    @(posedge core_clk);
    tx_addr <= a;
    tx_cmd <= c;
    btn <= 1'b1;
    rem <= 1'b0;
    while (frames < 3 && k < 4 * FRM)
    begin
      @(posedge core_clk);
      k++;
    end
    btn <= 1'b0;
    repeat (FRM + 300) @(posedge core_clk);
    #1 chk_n(frames, 3, "frame count");
    chk_v(dsp, disp(a, c + 8'h02), "loopback display");
  endtask
  initial
  begin
    logic [7:0] a;
    int n;
    void'($urandom(32'h4c31));
    do_reset();
    fifo_run(8'($urandom), 8'($urandom));
    tx_run(8'($urandom), 8'($urandom));
    tx_run(8'h00, 8'hFF);
    @(posedge core_clk);
    rem <= 1'b1;
    foreach (KEYS[i])
    begin
      a = 8'($urandom);
      n = ndone;
      if (i == 10)
      begin
        i_irp_far_model.send(8'hA5, 8'h55, 1'b1);
        #1 chk_n(ndone, n, "short lead space");
      end
      i_irp_far_model.send(a, KEYS[i], 1'b0);
      repeat (3) @(posedge core_clk);
      #1 chk_n(ndone - n, 1, "done pulse");
      chk_v(dsp, disp(a, KEYS[i]), "remote display");
    end
    give_verdict();
  end
  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // testbench
